/* File: rtl/scan_out_pkg.sv */
package scan_out_pkg;

  // ==========================================================
  // register byte addresses
  localparam logic [7:0] TDO_DATA_ADDR    = 8'h00;
  localparam logic [7:0] TMS0_DATA_ADDR   = 8'h08;
  localparam logic [7:0] TMS1_DATA_ADDR   = 8'h0C;
  localparam logic [7:0] FIRST_MODE_ADDR  = 8'h10;
  localparam logic [7:0] SECOND_MODE_ADDR = 8'h14;
  localparam logic [7:0] SHIFT_EN_ADDR    = 8'h18;
  localparam logic [7:0] STATUS_ADDR      = 8'h1C;

  // ==========================================================
  // first mode register fields
  localparam int LOOP_AROUND_BIT = 0;
  localparam int AUTO_HIGH_BIT   = 1;
  // second mode register fields
  localparam int LOOPBACK_LO_BIT = 0;
  localparam int LOOPBACK_HI_BIT = 1;
  localparam int RANDOM_BIT      = 4;
  // shift enable register fields
  localparam int TDO_EN_BIT  = 0;
  localparam int TMS0_EN_BIT = 1;
  localparam int TMS1_EN_BIT = 2;
  // status register fields
  localparam int ST_TDO_FULL   = 0;
  localparam int ST_TDO_EMPTY  = 1;
  localparam int ST_TMS0_FULL  = 2;
  localparam int ST_TMS0_EMPTY = 3;
  localparam int ST_TMS1_FULL  = 4;
  localparam int ST_TMS1_EMPTY = 5;
  localparam int ST_SEEDED     = 6;
  localparam int ST_TCK_HOLD   = 7;
  localparam int ST_BITCNT_LO  = 8;

  // ==========================================================
  // reset values and sizes
  localparam logic [7:0]  MODE_RESET      = 8'h00;
  localparam logic [2:0]  SHIFT_EN_RESET  = 3'h0;
  localparam int          BYTE_BITS       = 8;
  localparam int          SEED_BYTES      = 4;
  localparam logic [2:0]  LAST_BIT        = 3'h7;
  localparam logic [1:0]  LAST_SEED       = 2'h3;
  localparam logic [31:0] RANDOM_RESET    = 32'h0000_0001;

endpackage : scan_out_pkg

/* File: rtl/byte_pair_shifter.sv */
`timescale 1ns/1ps
module byte_pair_shifter
  import scan_out_pkg::*;
#(
  parameter int WIDTH = BYTE_BITS
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // parallel load
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_data,
  // shift control
  input  wire logic             shift,
  input  wire logic             swap,
  // state
  output logic                  bit_now,
  output logic                  full,
  output logic                  empty
);

  // ==========================================================
  // two byte registers, one shifting, one loading
  logic [WIDTH-1:0] byte_reg [2];
  logic [1:0]       occupied;
  logic             active;
  logic             load_sel;

  assign full     = (occupied == 2'h2);
  assign empty    = (occupied == 2'h0);
  assign load_sel = (occupied == 2'h0) ? active : ~active;
  assign bit_now  = byte_reg[active][0];

  // ==========================================================
  // swap drops any unshifted remainder of the old byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active   <= 1'b0;
      occupied <= 2'h0;
    end else begin
      if (swap) begin
        active <= ~active;
      end
      unique case ({load && !full, swap && !empty})
        2'b10:   occupied <= occupied + 2'h1;
        2'b01:   occupied <= occupied - 2'h1;
        default: occupied <= occupied;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_reg[0] <= '0;
      byte_reg[1] <= '0;
    end else begin
      if (shift) begin
        byte_reg[active] <= byte_reg[active] >> 1;
      end
      if (load && !full) begin
        byte_reg[load_sel] <= load_data;
      end
    end
  end

endmodule : byte_pair_shifter

/* File: rtl/scan_output_shifters.sv */
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module scan_output_shifters
  import scan_out_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // pins from outside the clock domain
  input  wire logic        sck,
  input  wire logic        output_disable,
  input  wire logic        tdi,
  // test clock control and shift length counter
  input  wire logic        tck_permit,
  input  wire logic        count_enable,
  input  wire logic        count_terminal,
  input  wire logic        count_is_one,
  output logic             tck_hold,
  // serial scan side pins
  output logic             tms0_out,
  output logic             tms0_oe,
  output logic             tms1_out,
  output logic             tms1_oe,
  output logic             tdo_out,
  output logic             tdo_oe
);

  // ==========================================================
  // pin synchronisers
  logic [1:0] sck_sync;
  logic [1:0] dis_sync;
  logic [1:0] tdi_sync;
  logic       sck_last;
  logic       sck_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_sync <= 2'h0;
      dis_sync <= 2'h0;
      tdi_sync <= 2'h3;
      sck_last <= 1'b0;
    end else begin
      sck_sync <= {sck_sync[0], sck};
      dis_sync <= {dis_sync[0], output_disable};
      tdi_sync <= {tdi_sync[0], tdi};
      sck_last <= sck_sync[1];
    end
  end

  // one pclk pulse per falling edge of the system clock
  assign sck_fall = sck_last && !sck_sync[1];

  // ==========================================================
  // apb register file, zero wait states
  logic       acc_write;
  logic       setup_rd;
  logic       addr_ok;
  logic [7:0] first_mode;
  logic [7:0] second_mode;
  logic [2:0] shift_en;
  logic       wr_tdo;
  logic       wr_tms0;
  logic       wr_tms1;
  logic       random_start;
  logic [31:0] status_word;

  assign addr_ok = (paddr == TDO_DATA_ADDR) || (paddr == TMS0_DATA_ADDR) ||
                   (paddr == TMS1_DATA_ADDR) || (paddr == FIRST_MODE_ADDR) ||
                   (paddr == SECOND_MODE_ADDR) || (paddr == SHIFT_EN_ADDR) ||
                   (paddr == STATUS_ADDR);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !addr_ok;
  assign acc_write = psel && penable && pwrite && addr_ok;
  assign setup_rd  = psel && !penable && !pwrite;
  assign wr_tdo    = acc_write && (paddr == TDO_DATA_ADDR);
  assign wr_tms0   = acc_write && (paddr == TMS0_DATA_ADDR);
  assign wr_tms1   = acc_write && (paddr == TMS1_DATA_ADDR);
  assign random_start = acc_write && (paddr == SECOND_MODE_ADDR) &&
                        pwdata[RANDOM_BIT] && !second_mode[RANDOM_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_mode  <= MODE_RESET;
      second_mode <= MODE_RESET;
      shift_en    <= SHIFT_EN_RESET;
    end else if (acc_write) begin
      if (paddr == FIRST_MODE_ADDR) begin
        first_mode <= pwdata[7:0];
      end
      if (paddr == SECOND_MODE_ADDR) begin
        second_mode <= pwdata[7:0];
      end
      if (paddr == SHIFT_EN_ADDR) begin
        shift_en <= pwdata[2:0];
      end
    end
  end

  // read data is latched in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_rd) begin
      unique case (paddr)
        FIRST_MODE_ADDR:  prdata <= {24'h00_0000, first_mode};
        SECOND_MODE_ADDR: prdata <= {24'h00_0000, second_mode};
        SHIFT_EN_ADDR:    prdata <= {29'h0000_0000, shift_en};
        STATUS_ADDR:      prdata <= status_word;
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // shift decisions
  logic random_mode;
  logic loopback_on;
  logic seeded;
  logic [1:0] seed_ptr;
  logic [2:0] bit_in_byte_counter;
  logic tc_seen;
  logic tc_pulse;
  logic tick;
  logic tdo_go;
  logic tms0_go;
  logic tms1_go;
  logic tdo_bit;
  logic tms0_bit;
  logic tms1_bit;
  logic tdo_full;
  logic tdo_empty;
  logic tms0_full;
  logic tms0_empty;
  logic tms1_full;
  logic tms1_empty;
  logic byte_done;
  logic force_high;
  logic [31:0] random_state;

  assign random_mode = second_mode[RANDOM_BIT];
  assign loopback_on = second_mode[LOOPBACK_HI_BIT] || second_mode[LOOPBACK_LO_BIT];
  assign tick        = sck_fall && tck_permit;
  assign tms0_go = tick && shift_en[TMS0_EN_BIT] && !tms0_empty;
  assign tms1_go = tick && shift_en[TMS1_EN_BIT] && !tms1_empty;
  assign tdo_go  = tick && shift_en[TDO_EN_BIT] &&
                   (random_mode ? seeded : !tdo_empty);
  assign byte_done = (tms0_go || tms1_go || (tdo_go && !random_mode)) &&
                     (bit_in_byte_counter == LAST_BIT);
  assign tc_pulse  = count_enable && count_terminal && !tc_seen;
  assign force_high = sck_fall && first_mode[AUTO_HIGH_BIT] && count_is_one;

  // stalls the test clock so a buffer never underruns
  assign tck_hold = (shift_en[TMS0_EN_BIT] && tms0_empty) ||
                    (shift_en[TMS1_EN_BIT] && tms1_empty) ||
                    (shift_en[TDO_EN_BIT] && (random_mode ? !seeded : tdo_empty));

  assign status_word = {21'h00_0000, bit_in_byte_counter, tck_hold, seeded,
                        tms1_empty, tms1_full, tms0_empty, tms0_full, tdo_empty, tdo_full};

  // terminal count is a level; act on its first cycle only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tc_seen <= 1'b0;
    end else begin
      tc_seen <= count_enable && count_terminal;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_in_byte_counter <= 3'h0;
    end else if (tc_pulse) begin
      bit_in_byte_counter <= 3'h0;
    end else if (tms0_go || tms1_go || (tdo_go && !random_mode)) begin
      bit_in_byte_counter <= bit_in_byte_counter + 3'h1;
    end
  end

  // ==========================================================
  // the three outgoing byte pairs
  byte_pair_shifter #(.WIDTH(BYTE_BITS)) u_tms0 (
    .pclk      (pclk),
    .presetn   (presetn),
    .load      (wr_tms0),
    .load_data (pwdata[7:0]),
    .shift     (tms0_go),
    .swap      ((tms0_go && byte_done) || (tc_pulse && shift_en[TMS0_EN_BIT])),
    .bit_now   (tms0_bit),
    .full      (tms0_full),
    .empty     (tms0_empty)
  );

  byte_pair_shifter #(.WIDTH(BYTE_BITS)) u_tms1 (
    .pclk      (pclk),
    .presetn   (presetn),
    .load      (wr_tms1),
    .load_data (pwdata[7:0]),
    .shift     (tms1_go),
    .swap      ((tms1_go && byte_done) || (tc_pulse && shift_en[TMS1_EN_BIT])),
    .bit_now   (tms1_bit),
    .full      (tms1_full),
    .empty     (tms1_empty)
  );

  // the byte pair stays beside the generator; it is idle while random mode runs
  byte_pair_shifter #(.WIDTH(BYTE_BITS)) u_tdo (
    .pclk      (pclk),
    .presetn   (presetn),
    .load      (wr_tdo && !random_mode),
    .load_data (pwdata[7:0]),
    .shift     (tdo_go && !random_mode),
    .swap      ((tdo_go && !random_mode && byte_done) ||
                (tc_pulse && shift_en[TDO_EN_BIT] && !random_mode)),
    .bit_now   (tdo_bit),
    .full      (tdo_full),
    .empty     (tdo_empty)
  );

  // ==========================================================
  // pseudo-random generator, x^32 + x^22 + x^2 + x + 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seed_ptr <= 2'h0;
      seeded   <= 1'b0;
    end else if (random_start) begin
      seed_ptr <= 2'h0;
      seeded   <= 1'b0;
    end else if (random_mode && wr_tdo && !seeded) begin
      seed_ptr <= seed_ptr + 2'h1;
      seeded   <= (seed_ptr == LAST_SEED);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      random_state <= RANDOM_RESET;
    end else if (random_mode && wr_tdo && !seeded && !random_start) begin
      random_state[8*seed_ptr +: 8] <= pwdata[7:0];
    end else if (random_mode && tdo_go) begin
      random_state <= {random_state[0] ^ random_state[10] ^ random_state[30] ^ random_state[31],
                       random_state[31:1]};
    end
  end

  // ==========================================================
  // serial outputs, all updated on a system clock falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tms0_out <= 1'b1;
      tms1_out <= 1'b1;
    end else if (force_high) begin
      tms0_out <= 1'b1;
      tms1_out <= 1'b1;
    end else if (!loopback_on) begin
      if (tms0_go) begin
        tms0_out <= tms0_bit;
      end
      if (tms1_go) begin
        tms1_out <= tms1_bit;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdo_out <= 1'b1;
    end else if (sck_fall && first_mode[LOOP_AROUND_BIT]) begin
      tdo_out <= tdi_sync[1];
    end else if (tdo_go && !loopback_on) begin
      tdo_out <= random_mode ? random_state[0] : tdo_bit;
    end
  end

  assign tms0_oe = !dis_sync[1];
  assign tms1_oe = !dis_sync[1];
  assign tdo_oe  = !dis_sync[1];

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_lsb_first_tms: assert property (tms0_go && !force_high && !loopback_on |=> tms0_out == $past(tms0_bit))
    else $error("tms0 did not present the active lsb");
  a_float_on_disable: assert property ($rose(dis_sync[1]) |-> !tms0_oe && !tms1_oe && !tdo_oe)
    else $error("outputs still driven while disabled");
  a_write_accepted: assert property (wr_tms0 && tms0_empty |=> !tms0_empty)
    else $error("write to empty buffer lost");
  a_hold_idle: assert property (!shift_en[TMS0_EN_BIT] && !force_high |=> $stable(tms0_out))
    else $error("disabled tms0 changed");
  a_loopback_hold: assert property (loopback_on && !first_mode[LOOP_AROUND_BIT] |=> $stable(tdo_out))
    else $error("tdo changed in loop-back");
  a_byte_wrap: assert property (byte_done && !tc_pulse |=> bit_in_byte_counter == 3'h0)
    else $error("bit counter did not wrap after eight");
  a_tc_clears: assert property (tc_pulse |=> bit_in_byte_counter == 3'h0)
    else $error("terminal count left bit counter");
  a_auto_high: assert property (force_high |=> tms0_out && tms1_out)
    else $error("auto-high not on both outputs");
  a_tdo_idle: assert property (!shift_en[TDO_EN_BIT] && !sck_fall |=> $stable(tdo_out))
    else $error("tdo moved without a shift");
  a_seed_restart: assert property (random_start |=> seed_ptr == 2'h0 && !seeded)
    else $error("seed pointer not reset");
  a_unseeded_still: assert property (random_mode && !seeded |-> !tdo_go)
    else $error("generator shifted before seeding");
  a_loop_around: assert property (sck_fall && first_mode[LOOP_AROUND_BIT] |=> tdo_out == $past(tdi_sync[1]))
    else $error("loop-around data wrong");
  a_clock_hold: assert property (shift_en[TMS1_EN_BIT] && tms1_empty |-> tck_hold)
    else $error("test clock not held on empty buffer");
  a_random_step: assert property (random_mode && tdo_go && !loopback_on && !first_mode[LOOP_AROUND_BIT]
                                  |=> tdo_out == $past(random_state[0]))
    else $error("generator bit not on tdo");

  c_tms0_swap: cover property (tms0_go && byte_done);
  c_tc_swap: cover property (tc_pulse && !tdo_empty);
  c_seeded: cover property (random_mode && $rose(seeded));
  c_auto_high: cover property (force_high && count_enable);

endmodule : scan_output_shifters

/* File: dv/scan_chain_model.sv */
`timescale 1ns/1ps
// ==========================================================
// far side: scan chain inputs and returned test data
module scan_chain_model (
  // pins driven by the scan controller
  input  wire logic       sck,
  input  wire logic       tms0_out,
  input  wire logic       tms0_oe,
  input  wire logic       tms1_out,
  input  wire logic       tms1_oe,
  input  wire logic       tdo_out,
  input  wire logic       tdo_oe,
  // levels seen by the chain, data returned
  output logic [2:0]      seen,
  output logic            tdi
);
  logic [2:0] level;
  logic [7:0] pattern;

  // released pins go to the chain's pull-up level, not the last value
  assign level = {tms1_oe ? tms1_out : 1'b1, tms0_oe ? tms0_out : 1'b1, tdo_oe ? tdo_out : 1'b1};

  initial begin
    seen = 3'h7;
    pattern = 8'hA5;
    tdi = 1'b1;
  end

  // chain samples on the rising test clock edge
  always @(posedge sck) begin
    seen <= level;
  end

  // returned data moves on the falling edge, a fresh pattern bit each cycle
  always @(negedge sck) begin
    pattern <= {pattern[6:0], pattern[7] ^ pattern[5] ^ pattern[4] ^ pattern[3]};
    tdi <= pattern[0];
  end
endmodule : scan_chain_model

/* File: dv/scan_output_shifters_test.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module scan_output_shifters_test;
  import scan_out_pkg::*;
  // ==========================================================
  // stimulus and observation
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, seed;
  logic        pready, pslverr, err, sck = 1, output_disable = 0, tdi, tck_hold;
  logic        tck_permit = 0, count_enable = 0, count_terminal = 0, count_is_one = 0;
  logic        tms0_out, tms0_oe, tms1_out, tms1_oe, tdo_out, tdo_oe;
  logic [2:0]  seen;
  logic [63:0] v;
  logic [7:0]  b0, b1, p;
  logic [7:0]  addr [3] = '{TDO_DATA_ADDR, TMS0_DATA_ADDR, TMS1_DATA_ADDR};
  int          error_cnt = 0, comparisons = 0, cycles = 0;

  always #12.5 pclk = ~pclk;
  // link clock, phase unrelated to pclk
  initial begin
    #37;
    forever #100 sck = ~sck;
  end

  scan_output_shifters DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .prdata, .sck, .output_disable, .tdi, .tck_permit, .count_enable, .count_terminal, .count_is_one,
    .tck_hold, .tms0_out, .tms0_oe, .tms1_out, .tms1_oe, .tdo_out, .tdo_oe);
  scan_chain_model chain (.sck, .tms0_out, .tms0_oe, .tms1_out, .tms1_oe, .tdo_out, .tdo_oe, .seen, .tdi);

  // ==========================================================
  // tasks
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // open the test clock just after a rise so every shift is whole
  task automatic run(input int n, input int ch);
    @(posedge sck);
    @(posedge pclk);
    tck_permit <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge sck);
      #1 v[i] = seen[ch];
    end
    @(posedge pclk);
    tck_permit <= 1'b0;
  endtask : run

  task automatic pulse;
    @(posedge pclk);
    count_terminal <= 1'b1;
    @(posedge pclk);
    count_terminal <= 1'b0;
    @(posedge pclk);
  endtask : pulse

  function automatic logic [39:0] prbs(input logic [31:0] s);
    for (int i = 0; i < 40; i++) begin
      prbs[i] = s[0];
      s = {s[0] ^ s[10] ^ s[30] ^ s[31], s[31:1]};
    end
  endfunction : prbs

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  // ==========================================================
  // scenarios
  initial begin
    seed = $urandom(26);
    repeat (10) @(posedge pclk);
    `CHK({tms0_out, tms1_out, tdo_out, tdo_oe}, 4'hF)
    presetn <= 1'b1;
    apb(0, STATUS_ADDR, 0);
    `CHK(r[5:0], 6'h2A)
    apb(0, FIRST_MODE_ADDR, 0);
    `CHK(r[7:0], MODE_RESET)
    apb(1, 8'h04, 32'hFF);
    `CHK({err, r}, 33'h1_0000_0000)
    $display("test reset done");
    // third byte must be dropped, written with every shift enable off
    for (int ch = 0; ch < 3; ch++) begin
      {p, b1, b0} = 24'($urandom());
      apb(1, addr[ch], {24'h0, b0});
      apb(1, addr[ch], {24'h0, b1});
      apb(1, addr[ch], {24'h0, p});
      apb(0, STATUS_ADDR, 0);
      `CHK(r[2 * ch], 1'b1)
      apb(1, SHIFT_EN_ADDR, 32'(1 << ch));
      run(16, ch);
      `CHK(v[15:0], {b1, b0})
      `CHK(tck_hold, 1'b1)
      apb(0, STATUS_ADDR, 0);
      `CHK(r[ST_BITCNT_LO +: 3], 3'h0)
      apb(1, SHIFT_EN_ADDR, 0);
      apb(1, addr[ch], {24'h0, {8{~b1[7]}}});
      run(8, ch);
      `CHK(v[7:0], {8{b1[7]}})
      $display("test channel %0d done", ch);
    end
    // tms1 holds the leftover byte; cut it short, then a partial byte
    b0 = {b0[7:3], 3'h3};
    apb(1, TMS1_DATA_ADDR, {24'h0, b0});
    count_enable <= 1'b1;
    apb(1, SHIFT_EN_ADDR, 32'(1 << TMS1_EN_BIT));
    run(3, 2);
    `CHK(v[2:0], {3{~b1[7]}})
    apb(0, STATUS_ADDR, 0);
    `CHK(r[ST_BITCNT_LO +: 3], 3'h3)
    pulse();
    apb(0, STATUS_ADDR, 0);
    `CHK(r[ST_BITCNT_LO +: 3], 3'h0)
    run(3, 2);
    `CHK(v[2:0], 3'h3)
    pulse();
    `CHK(tck_hold, 1'b1)
    count_enable <= 1'b0;
    $display("test terminal count done");
    // tms1 chain idle and parked low, tms0 shifting a pending byte while forced
    apb(1, FIRST_MODE_ADDR, 32'(1 << AUTO_HIGH_BIT));
    count_is_one <= 1'b1;
    apb(1, SHIFT_EN_ADDR, 32'(1 << TMS0_EN_BIT));
    run(1, 1);
    `CHK({v[0], seen[2]}, 2'h3)
    count_is_one <= 1'b0;
    apb(1, FIRST_MODE_ADDR, 0);
    $display("test auto high done");
    apb(1, SECOND_MODE_ADDR, 32'(1 << RANDOM_BIT));
    apb(1, SHIFT_EN_ADDR, 32'(1 << TDO_EN_BIT));
    seed = $urandom();
    for (int i = 0; i < 3; i++) apb(1, TDO_DATA_ADDR, {24'h0, seed[8 * i +: 8]});
    @(posedge pclk);
    `CHK(tck_hold, 1'b1)
    b0 = {8{seen[0]}};
    run(4, 0);
    `CHK(v[3:0], b0[3:0])
    apb(1, TDO_DATA_ADDR, {24'h0, seed[31:24]});
    apb(0, STATUS_ADDR, 0);
    `CHK({r[ST_SEEDED], tck_hold}, 2'h2)
    run(40, 0);
    `CHK(v[39:0], prbs(seed))
    apb(1, SECOND_MODE_ADDR, 0);
    apb(1, SHIFT_EN_ADDR, 0);
    $display("test random mode done");
    apb(1, FIRST_MODE_ADDR, 32'(1 << LOOP_AROUND_BIT));
    @(posedge sck);
    repeat (8) begin
      @(posedge sck);
      #1 `CHK(seen[0], tdi)
    end
    apb(1, FIRST_MODE_ADDR, 0);
    output_disable <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK({tms0_oe, tms1_oe, tdo_oe}, 3'h0)
    output_disable <= 1'b0;
    $display("test loop around and float done");
    // the tms0 buffer keeps shifting in loop-back, its pin must not move
    apb(1, SECOND_MODE_ADDR, 32'(1 << LOOPBACK_LO_BIT));
    apb(1, SHIFT_EN_ADDR, 32'(1 << TMS0_EN_BIT));
    b0 = {8{tms0_out}};
    apb(1, TMS0_DATA_ADDR, {24'h0, ~b0});
    run(8, 1);
    `CHK(v[7:0], b0)
    presetn <= 1'b0;
    @(posedge pclk);
    `CHK({tms0_out, tms1_out, tdo_out}, 3'h7)
    presetn <= 1'b1;
    $display("test loop back and reset done");
    summarize();
  end
endmodule : scan_output_shifters_test
